// [srg_map.svh]
// constants of the four stage shift register cell: widths, reset values, encodings
// assumes inclusion by bare name from the package and the shift register module
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH

`define SRG_STAGES        4
`define SRG_PIN_WIDTH     9
`define SRG_SYNC_DEPTH    2
`define SRG_STAGE_RESET   4'h0
`define SRG_CLK_RESET     1'b0
`define SRG_ARM_RESET     2'h0
`define SRG_ARM_DONE      2'h3
`define SRG_VAR_SERIAL    2'h0
`define SRG_VAR_SYNC_LOAD 2'h1
`define SRG_VAR_ASYNC     2'h3

`endif

// [srg_pin_drv.sv]
// partner model: the synchronous logic that drives the shift register cell's pins
// assumes clk is the cell's system clock; commands reach the pins one falling edge later
`timescale 1ns/1ps
`default_nettype none

module srg_pin_drv (
  input  wire logic               clk,
  input  wire srg_pkg::srg_pins_s cmd,
  output var  srg_pkg::srg_pins_s pins
);
  import srg_pkg::*;

  // registered like an upstream flop bank, so pins only move at a falling edge
  always @(negedge clk) begin
    pins <= cmd;
  end
endmodule

`default_nettype wire

// [srg_pkg.sv]
// types shared by the shift register cell and its pin driver
// assumes srg_map.svh sits in the same folder
`include "srg_map.svh"

package srg_pkg;

  // gray along serial -> sync load -> async load
  typedef enum logic [1:0] {
    SRG_SERIAL    = `SRG_VAR_SERIAL,
    SRG_SYNC_LOAD = `SRG_VAR_SYNC_LOAD,
    SRG_ASYNC     = `SRG_VAR_ASYNC
  } srg_variant_e;

  // a is the stage nearest the serial input, d the last
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } srg_quad_s;

  // every pin that enters from outside the clock domain
  typedef struct packed {
    logic         shift_clock;
    logic         serial_in;
    logic         parallel_load;
    logic [1:0]   variant;
    srg_quad_s    par_in;
  } srg_pins_s;

endpackage

// [srg_shift_reg.sv]
// four stage shift register cell family: serial only, synchronous load, asynchronous load
// assumes all pin inputs are asynchronous to clk and that shift_clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none

`include "srg_map.svh"

module srg_shift_reg (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [1:0]   variant,
  input  wire logic         shift_clock,
  input  wire logic         serial_in,
  input  wire logic         parallel_load,
  input  wire logic         par_in_a,
  input  wire logic         par_in_b,
  input  wire logic         par_in_c,
  input  wire logic         par_in_d,
  output var  logic         stage_out_a,
  output var  logic         stage_out_b,
  output var  logic         stage_out_c,
  output var  logic         stage_out_d
);
  import srg_pkg::*;

  srg_pins_s    pins;
  srg_pins_s    pins_s;
  srg_variant_e mode;
  srg_quad_s    stages;
  srg_quad_s    next_stages;
  logic         clk_prev;
  logic         next_clk_prev;
  logic         armed;
  logic [1:0]   arm_cnt;
  logic [1:0]   next_arm_cnt;
  logic         edge_fall;
  logic         edge_rise;
  logic         do_shift;
  logic         do_load;

  // one stage advance: serial bit into a, the rest move down
  function automatic srg_quad_s shift_once(input srg_quad_s cur, input logic ser);
    srg_quad_s r;
    r.a = ser;
    r.b = cur.a;
    r.c = cur.b;
    r.d = cur.c;
    return r;
  endfunction

  function automatic srg_variant_e decode_variant(input logic [1:0] v);
    case (v)
      `SRG_VAR_SYNC_LOAD: decode_variant = SRG_SYNC_LOAD;
      `SRG_VAR_ASYNC:     decode_variant = SRG_ASYNC;
      default:            decode_variant = SRG_SERIAL;
    endcase
  endfunction

  always_comb begin
    pins.shift_clock   = shift_clock;
    pins.serial_in     = serial_in;
    pins.parallel_load = parallel_load;
    pins.variant       = variant;
    pins.par_in.a      = par_in_a;
    pins.par_in.b      = par_in_b;
    pins.par_in.c      = par_in_c;
    pins.par_in.d      = par_in_d;
  end

  // every pin, shift_clock included, shares one synchroniser depth so they stay aligned
  srg_sync #(.W(`SRG_PIN_WIDTH)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins),
    .q   (pins_s)
  );

  assign mode = decode_variant(pins_s.variant);

  // synchroniser still shows reset zeros for two edges after release;
  // edges count only once clk_prev holds a real pin level, else a high pin fakes a rise
  assign armed     = (arm_cnt == `SRG_ARM_DONE);
  assign edge_fall = armed & clk_prev & ~pins_s.shift_clock;
  assign edge_rise = armed & ~clk_prev & pins_s.shift_clock;

  always_comb begin
    next_stages   = stages;
    next_clk_prev = pins_s.shift_clock;
    next_arm_cnt  = armed ? arm_cnt : arm_cnt + 2'h1;
    do_shift      = 1'b0;
    do_load       = 1'b0;
    case (mode)
      SRG_SYNC_LOAD: begin
        if (edge_fall) begin
          if (pins_s.parallel_load) begin
            do_load = 1'b1;
          end else begin
            do_shift = 1'b1;
          end
        end
      end
      SRG_ASYNC: begin
        // low load overrides clock and serial data entirely
        if (!pins_s.parallel_load) begin
          do_load = 1'b1;
        end else if (edge_rise) begin
          do_shift = 1'b1;
        end
      end
      default: begin
        if (edge_fall) begin
          do_shift = 1'b1;
        end
      end
    endcase
    if (do_load) begin
      next_stages = pins_s.par_in;
    end else if (do_shift) begin
      next_stages = shift_once(stages, pins_s.serial_in);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stages   <= `SRG_STAGE_RESET;
      clk_prev <= `SRG_CLK_RESET;
      arm_cnt  <= `SRG_ARM_RESET;
    end else begin
      stages   <= next_stages;
      clk_prev <= next_clk_prev;
      arm_cnt  <= next_arm_cnt;
    end
  end

  // outputs straight from the stage flops
  assign stage_out_a = stages.a;
  assign stage_out_b = stages.b;
  assign stage_out_c = stages.c;
  assign stage_out_d = stages.d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_serial_enters_a;
    (mode == SRG_SERIAL) && edge_fall |=> stage_out_a == $past(pins_s.serial_in);
  endproperty
  a_serial_enters_a: assert property (p_serial_enters_a)
    else $error("serial_in not captured into stage a on falling edge");

  property p_chain_moves;
    do_shift && !do_load |=>
      {stage_out_b, stage_out_c, stage_out_d} == $past({stages.a, stages.b, stages.c});
  endproperty
  a_chain_moves: assert property (p_chain_moves)
    else $error("stages b c d did not take old a b c");

  property p_hold_without_event;
    !do_shift && !do_load |=> $stable(stages) && stage_out_d == $past(stages.d);
  endproperty
  a_hold_without_event: assert property (p_hold_without_event)
    else $error("stages changed with no shift or load");

  property p_sync_load;
    (mode == SRG_SYNC_LOAD) && edge_fall && pins_s.parallel_load |=>
      stages == $past(pins_s.par_in);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("synchronous load did not take parallel inputs");

  property p_sync_shift;
    (mode == SRG_SYNC_LOAD) && edge_fall && !pins_s.parallel_load |=>
      stage_out_a == $past(pins_s.serial_in) && stage_out_b == $past(stages.a);
  endproperty
  a_sync_shift: assert property (p_sync_shift)
    else $error("synchronous variant did not shift with load low");

  property p_lane_mapping;
    do_load |=> stage_out_a == $past(pins_s.par_in.a) && stage_out_d == $past(pins_s.par_in.d);
  endproperty
  a_lane_mapping: assert property (p_lane_mapping)
    else $error("parallel input routed to wrong stage");

  property p_async_follow;
    ((mode == SRG_ASYNC) && !pins_s.parallel_load && $stable(pins_s.par_in)) [*3] |->
      ##1 stages == $past(pins_s.par_in);
  endproperty
  a_async_follow: assert property (p_async_follow)
    else $error("asynchronous load did not force stages");

  property p_async_shift_rise;
    (mode == SRG_ASYNC) && pins_s.parallel_load && edge_rise |=>
      stage_out_a == $past(pins_s.serial_in) && stage_out_c == $past(stages.b);
  endproperty
  a_async_shift_rise: assert property (p_async_shift_rise)
    else $error("asynchronous variant did not shift on rising edge");

  property p_async_ignores_fall;
    (mode == SRG_ASYNC) && pins_s.parallel_load && edge_fall |=> $stable(stages);
  endproperty
  a_async_ignores_fall: assert property (p_async_ignores_fall)
    else $error("asynchronous variant shifted on falling edge");

  property p_cov_serial_shift;
    (mode == SRG_SERIAL) && edge_fall;
  endproperty
  c_serial_shift: cover property (p_cov_serial_shift);

  property p_cov_sync_load;
    (mode == SRG_SYNC_LOAD) && edge_fall && pins_s.parallel_load;
  endproperty
  c_sync_load: cover property (p_cov_sync_load);

  property p_cov_async_both;
    (mode == SRG_ASYNC) && !pins_s.parallel_load ##[1:200]
      (mode == SRG_ASYNC) && edge_rise && pins_s.parallel_load;
  endproperty
  c_async_both: cover property (p_cov_async_both);

endmodule

`default_nettype wire

// [srg_shift_reg_tb_top.sv]
// self-checking bench of the four stage shift register cell, all variants
// assumes srg_pin_drv supplies the pins; expected stages tracked in exp, a as msb
`timescale 1ns/1ps
`default_nettype none

module srg_shift_reg_tb_top;
  import srg_pkg::*;

  logic       clk;
  logic       rst;
  srg_pins_s  cmd;
  srg_pins_s  pins;
  logic       qa, qb, qc, qd;
  logic [3:0] exp;
  int         errors;
  int         checked;

  always #2.5 clk = ~clk;

  srg_pin_drv drv_u (.clk(clk), .cmd(cmd), .pins(pins));

  srg_shift_reg dut_u (
    .clk           (clk),
    .rst           (rst),
    .variant       (pins.variant),
    .shift_clock   (pins.shift_clock),
    .serial_in     (pins.serial_in),
    .parallel_load (pins.parallel_load),
    .par_in_a      (pins.par_in.a),
    .par_in_b      (pins.par_in.b),
    .par_in_c      (pins.par_in.c),
    .par_in_d      (pins.par_in.d),
    .stage_out_a   (qa),
    .stage_out_b   (qb),
    .stage_out_c   (qc),
    .stage_out_d   (qd)
  );

  task automatic chk(input logic [3:0] e);
    checked++;
    if ({qa, qb, qc, qd} !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, {qa, qb, qc, qd}, e);
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data settles 4 cycles before any edge: the sampler needs 2 either side
  task automatic set_pins(input logic [1:0] v, input logic sd, input logic ld,
                          input logic [3:0] p);
    @(negedge clk);
    cmd.variant       <= v;
    cmd.serial_in     <= sd;
    cmd.parallel_load <= ld;
    cmd.par_in        <= p;
    hold(4);
  endtask

  // phases of 6 cycles, above the 3 cycle minimum of the edge sampler
  task automatic edge_to(input logic lvl);
    @(negedge clk);
    cmd.shift_clock <= lvl;
    hold(6);
  endtask

  // pattern 0,1,1,0,0 tells a wrong direction or a stuck stage apart
  task automatic t_serial(input logic [1:0] v);
    logic sd;
    for (int i = 0; i < 5; i++) begin
      sd = i[0] ^ i[1];
      set_pins(v, sd, 1'b0, 4'hf);
      edge_to(1'b1);
      chk(exp);
      edge_to(1'b0);
      exp = {sd, exp[3:1]};
      chk(exp);
    end
  endtask

  task automatic t_sync;
    set_pins(SRG_SYNC_LOAD, 1'b1, 1'b1, 4'ha);
    edge_to(1'b1);
    edge_to(1'b0);
    exp = 4'ha;
    chk(exp);
    set_pins(SRG_SYNC_LOAD, 1'b0, 1'b1, 4'h3);
    edge_to(1'b1);
    edge_to(1'b0);
    exp = 4'h3;
    chk(exp);
    set_pins(SRG_SYNC_LOAD, 1'b1, 1'b0, 4'hc);
    edge_to(1'b1);
    edge_to(1'b0);
    exp = 4'h9;
    chk(exp);
  endtask

  task automatic t_async;
    set_pins(SRG_ASYNC, 1'b1, 1'b0, 4'h6);
    chk(4'h6);
    edge_to(1'b1);
    chk(4'h6);
    set_pins(SRG_ASYNC, 1'b1, 1'b0, 4'h9);
    chk(4'h9);
    set_pins(SRG_ASYNC, 1'b0, 1'b1, 4'h6);
    edge_to(1'b0);
    chk(4'h9);
    edge_to(1'b1);
    chk(4'h4);
  endtask

  // mid-run reset with shift_clock and serial_in high: release must not fake a rise
  task automatic t_reset;
    set_pins(SRG_ASYNC, 1'b1, 1'b1, 4'h6);
    chk(4'h4);
    @(negedge clk);
    rst = 1'b1;
    hold(2);
    chk(4'h0);
    hold(2);
    rst = 1'b0;
    hold(8);
    chk(4'h0);
    edge_to(1'b0);
    chk(4'h0);
    edge_to(1'b1);
    chk(4'h8);
  endtask

  task automatic report_and_stop;
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk     = 1'b0;
    rst     = 1'b1;
    errors  = 0;
    checked = 0;
    exp     = 4'h0;
    cmd     = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    hold(3);
    chk(exp);
    t_serial(SRG_SERIAL);
    t_serial(2'h2);
    t_sync();
    t_async();
    t_reset();
    report_and_stop();
  end

  // whole run is near 340 cycles
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire

// [srg_sync.sv]
// two flip-flop synchroniser for the pin inputs of the shift register cell
// assumes inputs are asynchronous levels; output lags the pins by two clk edges
`timescale 1ns/1ps
`default_nettype none

module srg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= next_meta[i];
        q[i]    <= next_q[i];
      end
    end
  end

endmodule

`default_nettype wire
